// File: hdl/mpkrs_device.sv
// module end: turns key and restart pulse lengths into power states
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - host presses key only after stable supply
// - host waits 30 ms after supply first
// - key low 3 s starts power-up
// - grounded key powers on without pulse
// - grounded key ignores software shutdown command
// - key low 2.5 s while running shuts down
// - host waits 8 s before next power-on
// - shutdown completes then peripheral power removed
// - after soft shutdown any key low boots
// - host shuts down before removing supply
// - restart low 100 ms then release restarts
// - host only pulls lines low, never high
module mpkrs_device import mpkrs_pkg::*; #(
  parameter logic [MPKRS_CYC_W-1:0] CYC_PER_MS = MPKRS_CYC_PER_MS,
  parameter logic [MPKRS_MS_W-1:0] T_BOOT_MS = MPKRS_T_BOOT_MS,
  parameter logic [MPKRS_MS_W-1:0] T_SHUT_MS = MPKRS_T_SHUT_MS
) (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic auto_power_on_i,
  input wire logic soft_shutdown_command_i,
  input wire logic soft_restart_command_i,
  output logic module_on_o,
  output logic booting_o,
  output logic shutting_down_o,
  output logic periph_power_o,
  mpkrs_if.device link
);

  typedef enum logic [1:0] {ST_OFF, ST_BOOT, ST_ON, ST_SHUT} mpkrs_dst_t;

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [1:0] key_sync_reg, key_sync_next;
  logic [1:0] rst_sync_reg, rst_sync_next;
  logic [1:0] strap_sync_reg, strap_sync_next;
  logic key_lo;
  logic rst_lo;
  logic auto_mode;

  always_comb begin
    key_sync_next = {key_sync_reg[0], link.power_key_n};
    rst_sync_next = {rst_sync_reg[0], link.hard_restart_n};
    strap_sync_next = {strap_sync_reg[0], auto_power_on_i};
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      key_sync_reg <= MPKRS_SYNC_REL;
      rst_sync_reg <= MPKRS_SYNC_REL;
      strap_sync_reg <= 2'h0;
    end else begin
      key_sync_reg <= key_sync_next;
      rst_sync_reg <= rst_sync_next;
      strap_sync_reg <= strap_sync_next;
    end
  end

  assign key_lo = (key_sync_reg[1] == MPKRS_PIN_LOW);
  assign rst_lo = (rst_sync_reg[1] == MPKRS_PIN_LOW);
  // strap follows the board tie; it is static in practice
  assign auto_mode = strap_sync_reg[1];

  // ****************************************
  // millisecond tick
  // ****************************************
  logic [MPKRS_CYC_W-1:0] div_reg, div_next;
  logic tick;

  always_comb begin
    tick = (div_reg == CYC_PER_MS - MPKRS_CYC_ONE);
    div_next = tick ? MPKRS_CYC_ZERO : div_reg + MPKRS_CYC_ONE;
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      div_reg <= MPKRS_CYC_ZERO;
    end else begin
      div_reg <= div_next;
    end
  end

  // ****************************************
  // low-time meters
  // ****************************************
  logic [MPKRS_MS_W-1:0] key_ms_reg, key_ms_next;
  logic [MPKRS_MS_W-1:0] rst_ms_reg, rst_ms_next;
  logic rst_long_reg, rst_long_next;
  logic restart_evt;

  always_comb begin
    key_ms_next = MPKRS_MS_ZERO;
    rst_ms_next = MPKRS_MS_ZERO;
    // meters saturate so a held line never wraps into a short pulse
    if (key_lo) begin
      key_ms_next = key_ms_reg;
      if (tick && key_ms_reg != MPKRS_MS_MAX) begin
        key_ms_next = key_ms_reg + MPKRS_MS_ONE;
      end
    end
    if (rst_lo) begin
      rst_ms_next = rst_ms_reg;
      if (tick && rst_ms_reg != MPKRS_MS_MAX) begin
        rst_ms_next = rst_ms_reg + MPKRS_MS_ONE;
      end
    end
    // restart acts on release of a long enough press
    restart_evt = rst_long_reg && !rst_lo;
    rst_long_next = rst_lo && (rst_long_reg || rst_ms_reg >= MPKRS_T_RST_MS);
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      key_ms_reg <= MPKRS_MS_ZERO;
      rst_ms_reg <= MPKRS_MS_ZERO;
      rst_long_reg <= 1'h0;
    end else begin
      key_ms_reg <= key_ms_next;
      rst_ms_reg <= rst_ms_next;
      rst_long_reg <= rst_long_next;
    end
  end

  // ****************************************
  // power state machine
  // ****************************************
  mpkrs_dst_t st_reg, st_next;
  logic [MPKRS_MS_W-1:0] ph_ms_reg, ph_ms_next;
  logic armed_reg, armed_next;
  logic soft_off_reg, soft_off_next;
  logic on_reg, on_next;
  logic boot_reg, boot_next;
  logic shut_reg, shut_next;
  logic periph_reg, periph_next;

  always_comb begin
    st_next = st_reg;
    ph_ms_next = (tick && ph_ms_reg != MPKRS_MS_MAX) ?
                 ph_ms_reg + MPKRS_MS_ONE : ph_ms_reg;
    armed_next = armed_reg;
    soft_off_next = soft_off_reg;
    case (st_reg)
      ST_OFF: begin
        ph_ms_next = MPKRS_MS_ZERO;
        if (auto_mode) begin
          st_next = ST_BOOT;
        end else if (soft_off_reg && key_lo) begin
          st_next = ST_BOOT;
        end else if (key_ms_reg >= MPKRS_T_ON_MS) begin
          st_next = ST_BOOT;
        end
        if (st_next == ST_BOOT) begin
          soft_off_next = 1'h0;
        end
      end
      ST_BOOT: begin
        if (restart_evt || soft_restart_command_i) begin
          ph_ms_next = MPKRS_MS_ZERO;
        end else if (ph_ms_reg >= T_BOOT_MS) begin
          st_next = ST_ON;
        end
        // the power-on press must end before a power-off press counts
        armed_next = 1'h0;
      end
      ST_ON: begin
        if (!key_lo && !auto_mode) begin
          armed_next = 1'h1;
        end
        ph_ms_next = MPKRS_MS_ZERO;
        if (restart_evt || soft_restart_command_i) begin
          st_next = ST_BOOT;
        end else if (armed_reg && key_ms_reg >= MPKRS_T_OFF_MS) begin
          st_next = ST_SHUT;
        end else if (soft_shutdown_command_i && !auto_mode) begin
          st_next = ST_SHUT;
          soft_off_next = 1'h1;
        end
      end
      ST_SHUT: begin
        armed_next = 1'h0;
        // key ignored until the shutdown process has run out
        if (ph_ms_reg >= T_SHUT_MS) begin
          st_next = ST_OFF;
        end
      end
      default: begin
        st_next = ST_OFF;
      end
    endcase
    on_next = (st_next == ST_ON);
    boot_next = (st_next == ST_BOOT);
    shut_next = (st_next == ST_SHUT);
    periph_next = (st_next != ST_OFF);
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_reg <= ST_OFF;
      ph_ms_reg <= MPKRS_MS_ZERO;
      armed_reg <= 1'h0;
      soft_off_reg <= 1'h0;
      on_reg <= 1'h0;
      boot_reg <= 1'h0;
      shut_reg <= 1'h0;
      periph_reg <= 1'h0;
    end else begin
      st_reg <= st_next;
      ph_ms_reg <= ph_ms_next;
      armed_reg <= armed_next;
      soft_off_reg <= soft_off_next;
      on_reg <= on_next;
      boot_reg <= boot_next;
      shut_reg <= shut_next;
      periph_reg <= periph_next;
    end
  end

  assign module_on_o = on_reg;
  assign booting_o = boot_reg;
  assign shutting_down_o = shut_reg;
  assign periph_power_o = periph_reg;

endmodule : mpkrs_device
`default_nettype wire

// File: hdl/mpkrs_pkg.sv
// shared constants of the power key and hard restart sequencer
package mpkrs_pkg;

  // ****************************************
  // clock and millisecond tick
  // ****************************************
  localparam int MPKRS_CLK_HZ = 250_000_000;
  localparam int MPKRS_MS_PER_S = 1000;
  localparam int MPKRS_CYC_W = 20;
  localparam logic [MPKRS_CYC_W-1:0] MPKRS_CYC_PER_MS =
    MPKRS_CYC_W'(MPKRS_CLK_HZ / MPKRS_MS_PER_S);
  localparam logic [MPKRS_CYC_W-1:0] MPKRS_CYC_ZERO = 20'h00000;
  localparam logic [MPKRS_CYC_W-1:0] MPKRS_CYC_ONE = 20'h00001;

  // ****************************************
  // durations in milliseconds
  // ****************************************
  localparam int MPKRS_MS_W = 14;
  localparam logic [MPKRS_MS_W-1:0] MPKRS_MS_ZERO = 14'h0000;
  localparam logic [MPKRS_MS_W-1:0] MPKRS_MS_ONE = 14'h0001;
  localparam logic [MPKRS_MS_W-1:0] MPKRS_MS_MAX = 14'h3FFF;
  // 30 ms supply settle before first key press
  localparam logic [MPKRS_MS_W-1:0] MPKRS_T_SETTLE_MS = 14'h001E;
  // 3 s power-on press
  localparam logic [MPKRS_MS_W-1:0] MPKRS_T_ON_MS = 14'h0BB8;
  // 2.5 s power-off press
  localparam logic [MPKRS_MS_W-1:0] MPKRS_T_OFF_MS = 14'h09C4;
  // 8 s gap after power-off release
  localparam logic [MPKRS_MS_W-1:0] MPKRS_T_GAP_MS = 14'h1F40;
  // 100 ms hard restart press
  localparam logic [MPKRS_MS_W-1:0] MPKRS_T_RST_MS = 14'h0064;
  // device boot and shutdown process lengths
  localparam logic [MPKRS_MS_W-1:0] MPKRS_T_BOOT_MS = 14'h03E8;
  localparam logic [MPKRS_MS_W-1:0] MPKRS_T_SHUT_MS = 14'h07D0;
  // host margin above every minimum
  localparam logic [MPKRS_MS_W-1:0] MPKRS_T_MARGIN_MS = 14'h0064;

  // ****************************************
  // pin levels
  // ****************************************
  localparam logic [1:0] MPKRS_SYNC_REL = 2'h3;
  localparam logic MPKRS_PIN_LOW = 1'h0;
  localparam logic MPKRS_PIN_HIGH = 1'h1;

endpackage : mpkrs_pkg

// File: hdl/mpkrs_if.sv
// open-drain control lines between host and module
`timescale 1ns/100ps
`default_nettype none
interface mpkrs_if;
  logic key_out;
  logic key_oe_n;
  logic rst_out;
  logic rst_oe_n;
  logic key_grounded;
  logic power_key_n;
  logic hard_restart_n;

  // pulled up when nobody drives; a board tie forces the key low
  assign power_key_n = key_grounded ? 1'h0 : (key_oe_n ? 1'h1 : key_out);
  assign hard_restart_n = rst_oe_n ? 1'h1 : rst_out;

  modport host (
    output key_out,
    output key_oe_n,
    output rst_out,
    output rst_oe_n,
    input power_key_n,
    input hard_restart_n
  );

  modport device (
    input power_key_n,
    input hard_restart_n
  );
endinterface : mpkrs_if
`default_nettype wire

// File: hdl/mpkrs_host.sv
// host end: times key and restart pulses through open-drain outputs
`timescale 1ns/100ps
`default_nettype none
module mpkrs_host import mpkrs_pkg::*; #(
  parameter logic [MPKRS_CYC_W-1:0] CYC_PER_MS = MPKRS_CYC_PER_MS,
  parameter logic [MPKRS_MS_W-1:0] T_MARGIN_MS = MPKRS_T_MARGIN_MS
) (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic supply_ok_i,
  input wire logic power_on_req_i,
  input wire logic power_off_req_i,
  input wire logic restart_req_i,
  output logic ready_o,
  output logic busy_o,
  mpkrs_if.host link
);

  typedef enum logic [1:0] {H_SETTLE, H_IDLE, H_PULSE, H_GAP} mpkrs_hst_t;

  // ****************************************
  // supply synchroniser and ms tick
  // ****************************************
  logic [1:0] sup_sync_reg, sup_sync_next;
  logic [MPKRS_CYC_W-1:0] div_reg, div_next;
  logic tick;
  logic sup_ok;

  always_comb begin
    sup_sync_next = {sup_sync_reg[0], supply_ok_i};
    tick = (div_reg == CYC_PER_MS - MPKRS_CYC_ONE);
    div_next = tick ? MPKRS_CYC_ZERO : div_reg + MPKRS_CYC_ONE;
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sup_sync_reg <= 2'h0;
      div_reg <= MPKRS_CYC_ZERO;
    end else begin
      sup_sync_reg <= sup_sync_next;
      div_reg <= div_next;
    end
  end

  assign sup_ok = sup_sync_reg[1];

  // ****************************************
  // sequencer
  // ****************************************
  mpkrs_hst_t st_reg, st_next;
  logic [MPKRS_MS_W-1:0] ms_reg, ms_next;
  logic [MPKRS_MS_W-1:0] len_reg, len_next;
  logic gap_reg, gap_next;
  logic key_oe_n_reg, key_oe_n_next;
  logic rst_oe_n_reg, rst_oe_n_next;
  logic busy_reg, busy_next;
  logic done;

  always_comb begin
    st_next = st_reg;
    ms_next = (tick && ms_reg != MPKRS_MS_MAX) ? ms_reg + MPKRS_MS_ONE : ms_reg;
    len_next = len_reg;
    gap_next = gap_reg;
    key_oe_n_next = key_oe_n_reg;
    rst_oe_n_next = rst_oe_n_reg;
    done = (ms_reg >= len_reg);
    case (st_reg)
      H_SETTLE: begin
        // key stays released until supply settled plus margin
        len_next = MPKRS_T_SETTLE_MS + T_MARGIN_MS;
        if (!sup_ok) begin
          ms_next = MPKRS_MS_ZERO;
        end else if (done) begin
          st_next = H_IDLE;
        end
      end
      H_IDLE: begin
        ms_next = MPKRS_MS_ZERO;
        if (power_on_req_i) begin
          len_next = MPKRS_T_ON_MS + T_MARGIN_MS;
          key_oe_n_next = 1'h0;
          gap_next = 1'h0;
          st_next = H_PULSE;
        end else if (power_off_req_i) begin
          len_next = MPKRS_T_OFF_MS + T_MARGIN_MS;
          key_oe_n_next = 1'h0;
          gap_next = 1'h1;
          st_next = H_PULSE;
        end else if (restart_req_i) begin
          len_next = MPKRS_T_RST_MS + T_MARGIN_MS;
          rst_oe_n_next = 1'h0;
          gap_next = 1'h0;
          st_next = H_PULSE;
        end
      end
      H_PULSE: begin
        if (done) begin
          key_oe_n_next = 1'h1;
          rst_oe_n_next = 1'h1;
          ms_next = MPKRS_MS_ZERO;
          len_next = MPKRS_T_GAP_MS + T_MARGIN_MS;
          st_next = gap_reg ? H_GAP : H_IDLE;
        end
      end
      H_GAP: begin
        // key stays released for the whole shutdown gap
        if (done) begin
          st_next = H_IDLE;
        end
      end
      default: begin
        st_next = H_SETTLE;
      end
    endcase
    // supply loss drops everything; pins released, never driven high
    if (!sup_ok) begin
      st_next = H_SETTLE;
      key_oe_n_next = 1'h1;
      rst_oe_n_next = 1'h1;
    end
    busy_next = (st_next != H_IDLE);
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_reg <= H_SETTLE;
      ms_reg <= MPKRS_MS_ZERO;
      len_reg <= MPKRS_MS_ZERO;
      gap_reg <= 1'h0;
      key_oe_n_reg <= 1'h1;
      rst_oe_n_reg <= 1'h1;
      busy_reg <= 1'h1;
    end else begin
      st_reg <= st_next;
      ms_reg <= ms_next;
      len_reg <= len_next;
      gap_reg <= gap_next;
      key_oe_n_reg <= key_oe_n_next;
      rst_oe_n_reg <= rst_oe_n_next;
      busy_reg <= busy_next;
    end
  end

  // open-drain only: the driven value is always low
  assign link.key_out = MPKRS_PIN_LOW;
  assign link.rst_out = MPKRS_PIN_LOW;
  assign link.key_oe_n = key_oe_n_reg;
  assign link.rst_oe_n = rst_oe_n_reg;
  assign busy_o = busy_reg;
  assign ready_o = (st_reg == H_IDLE);

endmodule : mpkrs_host
`default_nettype wire

// File: tb/mpkrs_props.sv
// checker of the open-drain key and restart lines
`timescale 1ns/100ps
`default_nettype none
module mpkrs_props #(
  parameter int C = 2
) (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic key_out,
  input wire logic key_oe_n,
  input wire logic rst_out,
  input wire logic rst_oe_n,
  input wire logic key_grounded,
  input wire logic power_key_n,
  input wire logic hard_restart_n
);
  // ****************************************
  // press and gap counters
  // ****************************************
  int up_cnt;
  int key_cnt;
  int gap_cnt;
  int rst_cnt;
  logic last_off;
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      up_cnt <= 0;
      key_cnt <= 0;
      gap_cnt <= 0;
      rst_cnt <= 0;
      last_off <= 1'h0;
    end else begin
      up_cnt <= (up_cnt < 1000) ? up_cnt + 1 : up_cnt;
      key_cnt <= key_oe_n ? 0 : key_cnt + 1;
      gap_cnt <= key_oe_n ? gap_cnt + 1 : 0;
      rst_cnt <= rst_oe_n ? 0 : rst_cnt + 1;
      if ($rose(key_oe_n)) begin
        last_off <= key_cnt < 3000 * C;
      end
    end
  end
  // ****************************************
  // line properties
  // ****************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  sequence s_key_press;
    $fell(key_oe_n);
  endsequence
  sequence s_key_release;
    $rose(key_oe_n);
  endsequence
  sequence s_rst_press;
    $fell(rst_oe_n);
  endsequence
  drive_low_only_a: assert property (!key_out && !rst_out)
    else $error("host drives a line high");
  released_high_a: assert property ((key_oe_n && !key_grounded)
    |-> power_key_n) else $error("released key not high");
  first_press_wait_a: assert property (s_key_press
    |-> up_cnt >= 30 * C) else $error("key pressed before settle");
  press_steady_a: assert property (s_key_press
    |-> !key_oe_n [*8]) else $error("key press glitch");
  off_press_len_a: assert property (s_key_release
    |-> key_cnt >= 2500 * C) else $error("key press too short");
  on_press_len_a: assert property (s_key_release
    |-> key_cnt < 2999 * C || key_cnt >= 3001 * C)
    else $error("key press without margin");
  off_gap_a: assert property (last_off && $fell(key_oe_n)
    |-> gap_cnt >= 8000 * C) else $error("gap after off too short");
  restart_len_a: assert property ($rose(rst_oe_n)
    |-> rst_cnt >= 100 * C) else $error("restart press too short");
  restart_steady_a: assert property (s_rst_press
    |-> !hard_restart_n [*8]) else $error("restart press glitch");
endmodule : mpkrs_props
`default_nettype wire

// File: tb/mpkrs_tb.sv
// self-checking bench for host and device ends on one link
`timescale 1ns/100ps
`default_nettype none
module mpkrs_tb import mpkrs_pkg::*;;
  localparam int C = 2;
  localparam int T_BOOT = 100;
  localparam int T_SHUT = 200;
  localparam int T_ON = int'(MPKRS_T_ON_MS);
  localparam int T_OFF = int'(MPKRS_T_OFF_MS);
  localparam int T_GAP = int'(MPKRS_T_GAP_MS);
  localparam int T_RST = int'(MPKRS_T_RST_MS);
  localparam int T_SET = int'(MPKRS_T_SETTLE_MS);
  logic clk_sys_i, rstn_i, supply_ok, on_req, off_req, rst_req;
  logic ready, busy, auto_on, soft_off, soft_rst;
  logic on_o, boot_o, shut_o, periph_o;
  int bad_count = 0;
  int compares = 0;
  mpkrs_if lnk ();
  mpkrs_host #(.CYC_PER_MS(20'h00002)) mpkrs_host_i (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .supply_ok_i(supply_ok),
    .power_on_req_i(on_req), .power_off_req_i(off_req),
    .restart_req_i(rst_req), .ready_o(ready), .busy_o(busy), .link(lnk));
  mpkrs_device #(.CYC_PER_MS(20'h00002), .T_BOOT_MS(14'h0064),
    .T_SHUT_MS(14'h00C8)) mpkrs_device_i (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .auto_power_on_i(auto_on),
    .soft_shutdown_command_i(soft_off), .soft_restart_command_i(soft_rst),
    .module_on_o(on_o), .booting_o(boot_o), .shutting_down_o(shut_o),
    .periph_power_o(periph_o), .link(lnk));
  mpkrs_props #(.C(C)) mpkrs_props_i (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .key_out(lnk.key_out),
    .key_oe_n(lnk.key_oe_n), .rst_out(lnk.rst_out),
    .rst_oe_n(lnk.rst_oe_n), .key_grounded(lnk.key_grounded),
    .power_key_n(lnk.power_key_n), .hard_restart_n(lnk.hard_restart_n));
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic sig(input int s);
    case (s)
      0: return boot_o;
      1: return on_o;
      2: return shut_o;
      3: return ready;
      4: return periph_o;
      5: return lnk.hard_restart_n;
      default: return lnk.key_oe_n;
    endcase
  endfunction : sig
  // bounded wait, sampled one step after the edge
  task automatic wait_for(input int s, input logic v, input int lim,
      output int n);
    n = 0;
    while (sig(s) !== v && n < lim) begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end
  endtask : wait_for
  task automatic check(input logic ok, input string msg);
    compares++;
    if (ok !== 1'h1) begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask : check
  task automatic pulse(input int s);
    @(posedge clk_sys_i);
    #1;
    case (s)
      0: on_req = 1'h1;
      1: off_req = 1'h1;
      2: rst_req = 1'h1;
      3: soft_off = 1'h1;
      default: soft_rst = 1'h1;
    endcase
    @(posedge clk_sys_i);
    #1;
    {on_req, off_req, rst_req, soft_off, soft_rst} = '0;
  endtask : pulse
  task automatic do_reset();
    rstn_i = 1'h0;
    repeat (4) @(posedge clk_sys_i);
    #1;
    rstn_i = 1'h1;
  endtask : do_reset
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_supply();
    int n;
    wait_for(3, 1'h1, 300 * C, n);
    check(ready === 1'h1 && n >= (T_SET + 99) * C, "ready too early");
    check(periph_o === 1'h0, "supply cut while module powered");
    supply_ok = 1'h0;
    wait_for(3, 1'h0, 6, n);
    check(ready === 1'h0 && busy === 1'h1, "ready without supply");
    supply_ok = 1'h1;
    wait_for(3, 1'h1, 300 * C, n);
    check(ready === 1'h1 && n >= (T_SET + 99) * C, "settle skipped");
  endtask : t_supply
  task automatic t_power_on();
    int n;
    wait_for(3, 1'h1, 400 * C, n);
    pulse(0);
    check(lnk.power_key_n === 1'h0, "key not pulled");
    wait_for(0, 1'h1, 3100 * C, n);
    check(n >= (T_ON - 2) * C && n <= (T_ON + 1) * C + 8, "boot time");
    wait_for(1, 1'h1, T_BOOT * C + 8, n);
    check(on_o === 1'h1 && boot_o === 1'h0, "not on after boot");
  endtask : t_power_on
  task automatic t_restart();
    int n;
    wait_for(3, 1'h1, 400 * C, n);
    pulse(2);
    check(lnk.hard_restart_n === 1'h0, "restart not pulled");
    wait_for(5, 1'h1, 300 * C, n);
    check(lnk.hard_restart_n === 1'h1, "restart never released");
    check(n >= T_RST * C && on_o === 1'h1, "restart short or early");
    wait_for(0, 1'h1, 8, n);
    check(boot_o === 1'h1, "no boot after restart");
    wait_for(1, 1'h1, T_BOOT * C + 8, n);
    check(on_o === 1'h1, "not on after restart");
    pulse(4);
    wait_for(0, 1'h1, 4, n);
    check(boot_o === 1'h1, "soft restart ignored");
    // a second soft restart mid-boot must start the boot time over
    repeat (100) @(posedge clk_sys_i);
    #1;
    pulse(4);
    wait_for(1, 1'h1, T_BOOT * C + 8, n);
    check(on_o === 1'h1 && n >= (T_BOOT - 1) * C, "boot timer kept");
  endtask : t_restart
  task automatic t_hard_off();
    int n;
    wait_for(3, 1'h1, 400 * C, n);
    pulse(1);
    wait_for(2, 1'h1, 2600 * C, n);
    check(n >= (T_OFF - 2) * C && n <= (T_OFF + 1) * C + 8, "off time");
    check(periph_o === 1'h1 && on_o === 1'h0, "power cut early");
    wait_for(2, 1'h0, T_SHUT * C + 8, n);
    check(periph_o === 1'h0 && n >= (T_SHUT - 1) * C, "periph kept");
    wait_for(3, 1'h1, (T_GAP + 200) * C, n);
    check(ready === 1'h1 && n >= (T_GAP - 200) * C, "gap too short");
  endtask : t_hard_off
  task automatic t_soft_off();
    int n;
    t_power_on();
    pulse(3);
    wait_for(4, 1'h0, T_SHUT * C + 16, n);
    check(on_o === 1'h0 && shut_o === 1'h0, "soft shutdown failed");
    wait_for(3, 1'h1, 400 * C, n);
    pulse(0);
    wait_for(0, 1'h1, 16, n);
    check(boot_o === 1'h1, "key low did not boot");
    wait_for(3, 1'h1, 3200 * C, n);
    check(ready === 1'h1 && on_o === 1'h1, "not on after key boot");
  endtask : t_soft_off
  task automatic t_auto();
    int n;
    auto_on = 1'h1;
    lnk.key_grounded = 1'h1;
    do_reset();
    wait_for(0, 1'h1, 16, n);
    check(boot_o === 1'h1, "no boot on grounded key");
    wait_for(1, 1'h1, T_BOOT * C + 16, n);
    pulse(3);
    wait_for(4, 1'h0, 20, n);
    check(on_o === 1'h1 && periph_o === 1'h1, "grounded mode shut");
  endtask : t_auto
  // ****************************************
  // run control
  // ****************************************
  task automatic final_report();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : final_report
  initial begin
    clk_sys_i = 1'h0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end
  // about twice the expected run length
  initial begin
    #(80000 * 4);
    bad_count++;
    final_report();
  end
  initial begin
    {on_req, off_req, rst_req, soft_off, soft_rst, auto_on} = '0;
    supply_ok = 1'h1;
    lnk.key_grounded = 1'h0;
    do_reset();
    t_supply();
    t_power_on();
    t_restart();
    t_hard_off();
    t_soft_off();
    t_auto();
    final_report();
  end
endmodule : mpkrs_tb
`default_nettype wire
